/* design/adc_ctrl_params.svh */
// constants for the converter control block: offsets, fields, reset values
// assumes inclusion by bare name from the package and the register module
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
`define CSR_OFFSET 8'h34
`define RESU_OFFSET 8'h35
`define RESL_OFFSET 8'h36
`define ADDR_W 8
`define CSR_DONE_BIT 7
`define CSR_DOUBLE_BIT 6
`define CSR_PON_BIT 5
`define CSR_CH_HI 2
`define CSR_CH_LO 0
`define RESL_QUARTER_BIT 3
`define REG_RESET 8'h00
`define RES_W 10
`define CH_W 3
`define CONV_CYCLES 14
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define AXI_DW 32
`endif

/* design/adc_ctrl_pkg.sv */
// types shared by the converter control block
// assumes the params header is on the include path
`include "adc_ctrl_params.svh"
package adc_ctrl_pkg;
	typedef logic [`RES_W-1:0] result_t;
	typedef logic [`CH_W-1:0] channel_t;
	typedef enum logic [1:0] {DIV_HALF, DIV_ONE, DIV_QUARTER} clk_div_e;
	typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_e;
endpackage : adc_ctrl_pkg

/* design/adc_clock_prescaler.sv */
// converter clock prescaler: one-cycle tick at the chosen rate
// assumes clk is the cpu clock and rst is synchronous active high
`timescale 1ns/100ps
module adc_clock_prescaler
	import adc_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic run,
	input clk_div_e divSel,
	// tick out
	output logic tick
);
	logic [1:0] cnt_r;

	always_ff @(posedge clk)
	begin
		if (rst || !run)
			cnt_r <= 2'h0;
		else
			cnt_r <= cnt_r + 2'h1;
	end

	always_comb
	begin
		case (divSel)
			DIV_ONE: tick = run;
			DIV_HALF: tick = run && cnt_r[0];
			DIV_QUARTER: tick = run && (cnt_r == 2'h3);
			default: tick = 1'b0;
		endcase
	end
endmodule : adc_clock_prescaler

/* design/adc_control_result_regs.sv */
// converter control/status and result registers behind an axi4-lite slave
// assumes the analog core presents a sampled code on sarCode and range flags
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "adc_ctrl_params.svh"

module adc_control_result_regs
	import adc_ctrl_pkg::*;
#(
	parameter int CONV_CYCLES = `CONV_CYCLES
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite write address and data
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// low-power mode from the system
	input wire logic haltMode,
	// analog core
	input wire logic [`RES_W-1:0] sarCode,
	input wire logic aboveHighRef,
	input wire logic belowLowRef,
	output logic [`CH_W-1:0] channelSelect,
	output logic analogEnable,
	output logic sampleStrobe
);
	logic done_r;
	logic double_r;
	logic powerOn_r;
	logic [`CH_W-1:0] channel_r;
	logic quarter_r;
	result_t result_r;
	conv_state_e state_r;
	logic [15:0] cycCnt_r;
	logic awHeld_r;
	logic wHeld_r;
	logic [31:0] awAddr_r;
	logic [31:0] wData_r;
	logic wLane0_r;
	logic convTick;
	logic convDone;
	logic running;
	logic doWrite;
	logic doRead;
	logic readUpper;
	logic [31:0] rdNxt;
	logic rdMapped;
	logic wrMapped;
	logic [7:0] wrByte;
	clk_div_e divSel;
	result_t codeNxt;

	// register indices are not word aligned, so byte address is four times index
	function automatic logic [31:0] byteAddr(input logic [`ADDR_W-1:0] idx);
		byteAddr = {22'h0, idx, 2'b00};
	endfunction : byteAddr

	function automatic logic hits(input logic [31:0] a, input logic [`ADDR_W-1:0] idx);
		hits = (a == byteAddr(idx));
	endfunction : hits

	function automatic logic isMapped(input logic [31:0] a);
		isMapped = hits(a, `CSR_OFFSET) || hits(a, `RESU_OFFSET) || hits(a, `RESL_OFFSET);
	endfunction : isMapped

	// write channel: address and data taken in either order
	assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
	assign wrMapped = isMapped(awAddr_r);
	assign wrByte = wData_r[7:0];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			awHeld_r <= 1'b0;
			awAddr_r <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			else if (doWrite)
				awHeld_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wHeld_r <= 1'b0;
			wData_r <= 32'h0000_0000;
			wLane0_r <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_wready <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wLane0_r <= s_axi_wstrb[0];
			end
			else if (doWrite)
				wHeld_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else if (doWrite)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// control fields; reserved bits 4:3 and the done flag are not stored from writes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			double_r <= 1'b0;
			powerOn_r <= 1'b0;
			channel_r <= '0;
			quarter_r <= 1'b0;
		end
		else if (doWrite && wLane0_r)
		begin
			if (hits(awAddr_r, `CSR_OFFSET))
			begin
				double_r <= wrByte[`CSR_DOUBLE_BIT];
				powerOn_r <= wrByte[`CSR_PON_BIT];
				channel_r <= wrByte[`CSR_CH_HI:`CSR_CH_LO];
			end
			if (hits(awAddr_r, `RESL_OFFSET))
				quarter_r <= wrByte[`RESL_QUARTER_BIT];
		end
	end

	// read channel
	assign doRead = s_axi_arvalid && s_axi_arready;
	assign readUpper = doRead && hits(s_axi_araddr, `RESU_OFFSET);
	assign rdMapped = isMapped(s_axi_araddr);

	always_comb
	begin
		rdNxt = 32'h0000_0000;
		if (hits(s_axi_araddr, `CSR_OFFSET))
			rdNxt[7:0] = {done_r, double_r, powerOn_r, 2'b00, channel_r};
		else if (hits(s_axi_araddr, `RESU_OFFSET))
			rdNxt[7:0] = result_r[9:2];
		else if (hits(s_axi_araddr, `RESL_OFFSET))
			rdNxt[7:0] = {4'h0, quarter_r, 1'b0, result_r[1:0]};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (doRead)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdNxt;
				s_axi_rresp <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// converter clock and conversion sequencing
	assign running = powerOn_r && !haltMode;
	assign divSel = quarter_r ? DIV_QUARTER : (double_r ? DIV_ONE : DIV_HALF);

	adc_clock_prescaler u_prescaler (
		.clk(clk),
		.rst(rst),
		.run(running),
		.divSel(divSel),
		.tick(convTick)
	);

	assign convDone = (state_r == CONV_RUN) && convTick &&
		(cycCnt_r == 16'(CONV_CYCLES - 1));

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= CONV_IDLE;
			cycCnt_r <= 16'h0000;
		end
		else
		begin
			case (state_r)
				CONV_IDLE:
				begin
					cycCnt_r <= 16'h0000;
					if (running)
						state_r <= CONV_RUN;
				end
				CONV_RUN:
				begin
					if (!running)
						state_r <= CONV_IDLE;
					else if (convDone)
						cycCnt_r <= 16'h0000;
					else if (convTick)
						cycCnt_r <= cycCnt_r + 16'h0001;
				end
				default: state_r <= CONV_IDLE;
			endcase
		end
	end

	// clamp out-of-range inputs
	always_comb
	begin
		if (aboveHighRef)
			codeNxt = '1;
		else if (belowLowRef)
			codeNxt = '0;
		else
			codeNxt = sarCode;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			result_r <= '0;
		else if (convDone)
			result_r <= codeNxt;
	end

	// set wins over the clearing read; polled only, no interrupt output
	always_ff @(posedge clk)
	begin
		if (rst)
			done_r <= 1'b0;
		else if (convDone)
			done_r <= 1'b1;
		else if (readUpper)
			done_r <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			channelSelect <= '0;
			analogEnable <= 1'b0;
			sampleStrobe <= 1'b0;
		end
		else
		begin
			channelSelect <= channel_r;
			analogEnable <= running;
			sampleStrobe <= convDone;
		end
	end
endmodule : adc_control_result_regs

/* tb/adc_core_model.sv */
// analog core stand-in: a code per channel, clamp flags on command
// assumes the block's enable and channel outputs on the cpu clock
`timescale 1ns/100ps
module adc_core_model
(
	// clock
	input wire logic clk,
	// from the block
	input wire logic [2:0] channelSelect,
	input wire logic analogEnable,
	// scenario commands
	input wire logic forceHigh,
	input wire logic forceLow,
	// to the block
	output logic [9:0] sarCode,
	output logic aboveHighRef,
	output logic belowLowRef
);
	assign aboveHighRef = forceHigh;
	assign belowLowRef = forceLow;
	// code is only meaningful while enabled
	always @(posedge clk)
	begin
		if (analogEnable)
			sarCode <= {channelSelect, 7'h2B};
		else
			sarCode <= ~{channelSelect, 7'h2B};
	end
endmodule : adc_core_model

/* tb/adc_ctrl_props.sv */
// port checker for the converter block
// assumes binding onto the block's top module
`timescale 1ns/100ps
module adc_ctrl_props #(parameter int CONV_CYCLES = 14)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter
	input wire logic haltMode,
	input wire logic analogEnable,
	input wire logic sampleStrobe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	a_reset_quiet: assert property ($fell(rst) |-> !analogEnable && !s_axi_rvalid)
		else $error("busy after reset");
	a_halt_off: assert property (haltMode |=> !analogEnable)
		else $error("enabled in halt");
	a_strobe_idle: assert property (!analogEnable [*3] |-> !sampleStrobe)
		else $error("strobe while off");
	a_strobe_pulse: assert property (sampleStrobe |=> !sampleStrobe)
		else $error("strobe too long");
	a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp
		== (($past(s_axi_araddr) inside {32'h0000_00D0, 32'h0000_00D4, 32'h0000_00D8})
		? 2'b00 : 2'b10))
		else $error("bad read answer");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read data dropped");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("upper data bits set");
endmodule : adc_ctrl_props
bind adc_control_result_regs adc_ctrl_props #(.CONV_CYCLES(CONV_CYCLES)) props_u (.*);

/* tb/test_adc_control_result_regs.sv */
// self-checking bench for the converter control block
// assumes the design, the core model and the checker compile first
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failCount++; \
	$display("MISMATCH %0t %h %h", $time, a, e); end end
module test_adc_control_result_regs;
	localparam int CC = 2;
	localparam logic [31:0] CSR = 32'h0000_00D0;
	localparam logic [31:0] UPR = 32'h0000_00D4;
	localparam logic [31:0] LWR = 32'h0000_00D8;
	logic clk, rst, awV, awR, wV, wR, bV, bRdy, arV, arR, rV, rRdy, haltMode;
	logic hiRef, loRef, anEn, strobe, forceHigh, forceLow;
	logic [31:0] awA, wD, arA, rD;
	logic [1:0] bResp, rResp;
	logic [9:0] code;
	logic [2:0] chSel;
	int failCount = 0;
	int comparisons = 0;
	adc_control_result_regs #(.CONV_CYCLES(CC)) dut_u (.clk(clk), .rst(rst),
		.s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp),
		.s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA), .s_axi_arvalid(arV),
		.s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV),
		.s_axi_rready(rRdy), .haltMode(haltMode), .sarCode(code), .aboveHighRef(hiRef),
		.belowLowRef(loRef), .channelSelect(chSel), .analogEnable(anEn), .sampleStrobe(strobe));
	adc_core_model core_u (.clk(clk), .channelSelect(chSel), .analogEnable(anEn),
		.forceHigh(forceHigh), .forceLow(forceLow), .sarCode(code), .aboveHighRef(hiRef),
		.belowLowRef(loRef));
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		awA <= a;
		wD <= {24'h00_0000, d};
		{awV, wV, bRdy} <= 3'h7;
		do
		begin
			@(posedge clk);
			if (awR) awV <= 1'b0;
			if (wR) wV <= 1'b0;
		end
		while (bV !== 1'b1);
		bRdy <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [7:0] d, output logic [1:0] r);
		arA <= a;
		{arV, rRdy} <= 2'h3;
		do
		begin
			@(posedge clk);
			if (arR) arV <= 1'b0;
		end
		while (rV !== 1'b1);
		d = rD[7:0];
		r = rResp;
		rRdy <= 1'b0;
		@(posedge clk);
	endtask : rd
	task automatic rdChk(input logic [31:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK({r, d}, {2'b00, e})
	endtask : rdChk
	task test_access;
		logic [7:0] d;
		logic [1:0] r;
		rdChk(CSR, 8'h00);
		rdChk(UPR, 8'h00);
		rdChk(LWR, 8'h00);
		wr(CSR, 8'hDF);
		rdChk(CSR, 8'h47);
		wr(LWR, 8'hFF);
		rdChk(LWR, 8'h08);
		wr(UPR, 8'hAA);
		rdChk(UPR, 8'h00);
		rd(32'h0000_00DC, d, r);
		`CHK(r, 2'b10)
		wr(CSR, 8'h00);
		wr(LWR, 8'h00);
	endtask : test_access
	task automatic test_convert(input logic [2:0] ch, input logic [9:0] res);
		int n = 0;
		logic [7:0] d;
		logic [1:0] r;
		wr(CSR, {3'b001, 2'b00, ch});
		do
		begin
			rd(CSR, d, r);
			n++;
		end
		while (d[7] !== 1'b1 && n < 20);
		`CHK(d[7], 1'b1)
		haltMode <= 1'b1;
		rdChk(LWR, {6'h00, res[1:0]});
		rdChk(UPR, res[9:2]);
		rdChk(CSR, {3'b001, 2'b00, ch});
		`CHK(chSel, ch)
		`CHK(anEn, 1'b0)
		wr(CSR, 8'h00);
		haltMode <= 1'b0;
	endtask : test_convert
	task test_channels;
		for (int c = 0; c < 7; c++)
			test_convert(3'(c), {3'(c), 7'h2B});
		forceHigh <= 1'b1;
		test_convert(3'h1, 10'h3FF);
		{forceHigh, forceLow} <= 2'h1;
		test_convert(3'h2, 10'h000);
		forceLow <= 1'b0;
	endtask : test_channels
	task automatic period(input int e);
		int n = 0;
		repeat (2)
		begin
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (strobe !== 1'b1 && n < 100);
		end
		`CHK(n, e)
	endtask : period
	task test_divider;
		wr(CSR, 8'h20);
		period(2 * CC);
		wr(CSR, 8'h60);
		period(CC);
		wr(LWR, 8'h08);
		period(4 * CC);
		wr(CSR, 8'h00);
	endtask : test_divider
	task test_reset;
		wr(CSR, 8'h62);
		wr(LWR, 8'h08);
		repeat (40) @(posedge clk);
		rdChk(CSR, 8'hE2);
		rdChk(UPR, 8'h4A);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK(anEn, 1'b0)
		rdChk(CSR, 8'h00);
		rdChk(UPR, 8'h00);
		rdChk(LWR, 8'h00);
	endtask : test_reset
	task print_verdict;
		if (failCount == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		#500000;
		failCount++;
		print_verdict;
	end
	initial
	begin
		rst <= 1'b1;
		{awV, wV, bRdy, arV, rRdy, haltMode, forceHigh, forceLow} <= 8'h00;
		{awA, wD, arA} <= '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		test_access;
		test_channels;
		test_divider;
		test_reset;
		print_verdict;
	end
endmodule : test_adc_control_result_regs
